// ==== pkg/pps_map.vh ====
/*
  Constants for the ping-pong timer sequencer: control bit positions,
  field codes and reset values.
  Assumes inclusion by bare name from the design file.
*/
`ifndef PPS_MAP_VH
`define PPS_MAP_VH
`define PPS_EN_BIT       7
`define PPS_SP_BIT       6
`define PPS_TO_BIT       5
`define PPS_IE_BIT       1
`define PPS_PIN_BIT      0
`define PPS_COMB_EN_BIT  6
`define PPS_COMB_HI      5
`define PPS_COMB_LO      4
`define PPS_MODE_HI      3
`define PPS_MODE_LO      2
`define PPS_INIT8_BIT    1
`define PPS_INIT16_BIT   0
`define PPS_MODE_NORMAL  2'h0
`define PPS_MODE_PINGPONG 2'h1
`define PPS_MODE_FORCE0  2'h2
`define PPS_MODE_FORCE1  2'h3
`define PPS_COMB_AND     2'h0
`define PPS_COMB_OR      2'h1
`define PPS_COMB_NOR     2'h2
`define PPS_COMB_NAND    2'h3
`define PPS_CNT8_RST     8'h00
`define PPS_CNT16_RST    16'h0000
`endif

// ==== rtl/pps_ping_pong_timer_sequencer.v ====
/*
  Ping-pong timer sequencer: an 8-bit and a 16-bit down-counter in transmit
  mode that hand over to each other, with port 3 bit 4..6 output routing.
  Assumes control bits arrive as synchronous ports and that set/clear of
  enable and timeout bits come as one-cycle strobes from software.
*/
`timescale 1ns/100ps
`default_nettype none
`include "pps_map.vh"

// Contract
// R1: Ping-pong needs transmit mode, both timers single-pass, mode field set.
// R2: Setting either timer's enable starts the ping-pong sequence.
// R3: Short timer enable sets output to init level, loads high or low reload.
// R4: Short terminal count disables short timer and enables long timer.
// R5: Long timer enable sets output to init level, loads sixteen-bit reload.
// R6: Long terminal count stops it and re-enables short timer, repeating.
// R7: Each terminal count requests an interrupt if that timer enables it.
// R8: Writing mode code zero ends ping-pong handover.
// R9: Software should stop timers and clear flags before enabling ping-pong.
// R10: Software never programs an initial count of one.
// R11: Re-enabling a timer reloads its counter, discarding partial counts.
// R12: Hardware sets and clears enable bits alternately; software reads them.
// R13: Timeout status sets at every terminal count.
// R14: Short pin control routes short timer output to port 3 bit 4.
// R15: Long pin control routes long timer output to port 3 bit 5.
// R16: Combine enable drives port 3 bit 6 with selected output combination.
// R17: Single-pass short timer stops at zero, toggles, flags, interrupts.
// R18: Long timer toggles its output at zero in transmit.
// R19: Four combine codes give AND, OR, NOR and NAND.
// R20: Mode code one selects ping-pong; two and three force the long output.
module pps_ping_pong_timer_sequencer (
  // Clock and reset.
  input  wire        mclk,
  input  wire        sys_rst,
  // Short timer control.
  input  wire        short_enable_set,
  input  wire        short_enable_clr,
  input  wire        short_single_pass,
  input  wire        short_int_enable,
  input  wire        short_pin_enable,
  input  wire        short_timeout_clr,
  // Long timer control.
  input  wire        long_enable_set,
  input  wire        long_enable_clr,
  input  wire        long_single_pass,
  input  wire        long_int_enable,
  input  wire        long_pin_enable,
  input  wire        long_timeout_clr,
  // Shared timer mode control.
  input  wire [7:0]  shared_timer_mode_control,
  // Reload values.
  input  wire [7:0]  short_reload_high,
  input  wire [7:0]  short_reload_low,
  input  wire [7:0]  long_reload_high_byte,
  input  wire [7:0]  long_reload_low_byte,
  // Status.
  output reg         short_enabled_q,
  output reg         long_enabled_q,
  output reg         short_timeout_q,
  output reg         long_timeout_q,
  output reg         short_irq_q,
  output reg         long_irq_q,
  // Port pins.
  output reg         port3_bit4_pin,
  output reg         port3_bit4_oe,
  output reg         port3_bit5_pin,
  output reg         port3_bit5_oe,
  output reg         port3_bit6_pin,
  output reg         port3_bit6_oe
);

  reg  [7:0]  short_down_counter;
  reg  [15:0] long_down_counter;
  reg         short_timer_output;
  reg         long_out_raw;
  reg         short_run_q;
  reg         long_run_q;
  reg         comb;
  wire [1:0]  mode      = shared_timer_mode_control[`PPS_MODE_HI:`PPS_MODE_LO];
  wire [1:0]  comb_sel  = shared_timer_mode_control[`PPS_COMB_HI:`PPS_COMB_LO];
  wire        init8     = shared_timer_mode_control[`PPS_INIT8_BIT];
  wire        init16    = shared_timer_mode_control[`PPS_INIT16_BIT];
  wire        ping_pong = (mode == `PPS_MODE_PINGPONG) && short_single_pass
                          && long_single_pass; // R1 R20 R8
  wire        short_tc  = short_run_q && (short_down_counter == 8'h01);
  wire        long_tc   = long_run_q && (long_down_counter == 16'h0001);
  wire        short_go  = short_enable_set || (ping_pong && long_tc); // R2 R6
  wire        long_go   = long_enable_set || (ping_pong && short_tc); // R2 R4
  wire        long_timer_output;

  // Forced codes override the long output whether running or not.
  assign long_timer_output = (mode == `PPS_MODE_FORCE0) ? 1'b0 :
                             (mode == `PPS_MODE_FORCE1) ? 1'b1 : long_out_raw; // R20

  // Short timer: load on enable, count down, stop or reload at terminal count.
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      short_down_counter <= `PPS_CNT8_RST;
      short_timer_output <= 1'b1;
      short_run_q        <= 1'b0;
    end
    else if (short_go)
    begin
      short_timer_output <= init8; // R3
      short_down_counter <= init8 ? short_reload_high : short_reload_low; // R3 R11
      short_run_q        <= 1'b1;
    end
    else if (short_enable_clr)
    begin
      short_run_q <= 1'b0;
    end
    else if (short_tc)
    begin
      short_timer_output <= ~short_timer_output; // R17
      if (short_single_pass)
      begin
        short_run_q <= 1'b0; // R17 R4
      end
      else
      begin
        short_down_counter <= short_timer_output ? short_reload_low : short_reload_high;
      end
    end
    else if (short_run_q)
    begin
      short_down_counter <= short_down_counter - 8'h01;
    end
    else if (!short_run_q)
    begin
      short_timer_output <= ~init8;
    end
  end

  // Long timer: load concatenated reload on enable, toggle at terminal count.
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      long_down_counter <= `PPS_CNT16_RST;
      long_out_raw      <= 1'b1;
      long_run_q        <= 1'b0;
    end
    else if (long_go)
    begin
      long_out_raw      <= init16; // R5
      long_down_counter <= {long_reload_high_byte, long_reload_low_byte}; // R5 R11
      long_run_q        <= 1'b1;
    end
    else if (long_enable_clr)
    begin
      long_run_q <= 1'b0;
    end
    else if (long_tc)
    begin
      long_out_raw <= ~long_out_raw; // R18
      if (long_single_pass)
      begin
        long_run_q <= 1'b0; // R6
      end
      else
      begin
        long_down_counter <= {long_reload_high_byte, long_reload_low_byte};
      end
    end
    else if (long_run_q)
    begin
      long_down_counter <= long_down_counter - 16'h0001;
    end
    else
    begin
      long_out_raw <= ~init16;
    end
  end

  // Status flags: hardware set wins over software clear.
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      short_enabled_q <= 1'b0;
      long_enabled_q  <= 1'b0;
      short_timeout_q <= 1'b0;
      long_timeout_q  <= 1'b0;
      short_irq_q     <= 1'b0;
      long_irq_q      <= 1'b0;
    end
    else
    begin
      short_enabled_q <= short_go || (short_run_q && !short_enable_clr
                         && !(short_tc && short_single_pass)); // R12
      long_enabled_q  <= long_go || (long_run_q && !long_enable_clr
                         && !(long_tc && long_single_pass)); // R12
      short_timeout_q <= short_tc || (short_timeout_q && !short_timeout_clr); // R13 R17
      long_timeout_q  <= long_tc || (long_timeout_q && !long_timeout_clr); // R13
      short_irq_q     <= short_tc && short_int_enable; // R7 R17
      long_irq_q      <= long_tc && long_int_enable; // R7
    end
  end

  // Combination of both timer outputs for port 3 bit 6.
  always @*
  begin
    case (comb_sel) // R19
      `PPS_COMB_AND:  comb = short_timer_output & long_timer_output;
      `PPS_COMB_OR:   comb = short_timer_output | long_timer_output;
      `PPS_COMB_NOR:  comb = ~(short_timer_output | long_timer_output);
      `PPS_COMB_NAND: comb = ~(short_timer_output & long_timer_output);
      default:        comb = 1'b0;
    endcase
  end

  // Registered pin routing.
  always @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      port3_bit4_pin <= 1'b0;
      port3_bit4_oe  <= 1'b0;
      port3_bit5_pin <= 1'b0;
      port3_bit5_oe  <= 1'b0;
      port3_bit6_pin <= 1'b0;
      port3_bit6_oe  <= 1'b0;
    end
    else
    begin
      port3_bit4_pin <= short_timer_output; // R14
      port3_bit4_oe  <= short_pin_enable; // R14
      port3_bit5_pin <= long_timer_output; // R15
      port3_bit5_oe  <= long_pin_enable; // R15
      port3_bit6_pin <= comb; // R16
      port3_bit6_oe  <= shared_timer_mode_control[`PPS_COMB_EN_BIT]; // R16
    end
  end

endmodule
`default_nettype wire

// ==== tb/pps_timer_props.sv ====
/* Assertion checker for the ping-pong timer sequencer ports.
   Assumes one clock, mclk, and sys_rst active high. */
`timescale 1ns/100ps
`default_nettype none
module pps_timer_props (
  // Clock and reset.
  input wire logic       mclk,
  input wire logic       sys_rst,
  // Controls.
  input wire logic       short_enable_clr,
  input wire logic       short_int_enable,
  input wire logic       short_pin_enable,
  input wire logic       short_single_pass,
  input wire logic       long_single_pass,
  input wire logic [7:0] shared_timer_mode_control,
  // Status and pins.
  input wire logic       short_enabled_q,
  input wire logic       long_enabled_q,
  input wire logic       short_timeout_q,
  input wire logic       long_timeout_q,
  input wire logic       short_irq_q,
  input wire logic       long_irq_q,
  input wire logic       port3_bit4_oe
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // A start, and a short pass ending by count rather than by a stop.
  sequence s_short_go;
    $rose(short_enabled_q) && !short_enable_clr;
  endsequence
  sequence s_short_done;
    $fell(short_enabled_q) && !$past(short_enable_clr)
      && $past(shared_timer_mode_control[3:2]) == 2'h1
      && $past(short_single_pass && long_single_pass);
  endsequence
  a_short_handover: assert property (s_short_done |-> long_enabled_q)
    else $error("long timer not started after short pass");
  a_long_handover: assert property (long_irq_q
    && $past(shared_timer_mode_control[3:2]) == 2'h1
    && $past(short_single_pass && long_single_pass) |-> short_enabled_q)
    else $error("short timer not restarted after long pass");
  a_irq_gate: assert property (short_irq_q |-> $past(short_int_enable))
    else $error("short interrupt while disabled");
  a_short_flag: assert property (short_irq_q |-> short_timeout_q)
    else $error("short timeout flag missing");
  a_long_flag: assert property (long_irq_q |-> long_timeout_q)
    else $error("long timeout flag missing");
  a_irq_pulse: assert property (short_irq_q |=> !short_irq_q)
    else $error("short interrupt longer than one cycle");
  a_pin4_route: assert property (port3_bit4_oe == $past(short_pin_enable))
    else $error("short pin not driven");
  a_start_len: assert property (s_short_go |-> short_enabled_q [*2])
    else $error("short pass shorter than two cycles");
endmodule
bind pps_ping_pong_timer_sequencer pps_timer_props u_pps_timer_props (.*);
`default_nettype wire

// ==== tb/pps_ping_pong_timer_sequencer_tb.sv ====
/* Self-checking bench for the ping-pong timer sequencer.
   Assumes a 250 MHz clock and registered pins. */
`timescale 1ns/100ps
`default_nettype none
module pps_ping_pong_timer_sequencer_tb;
  logic      mclk = 1'b0, sys_rst = 1'b1, pen = 1'b0, sp = 1'b1;
  logic [5:0] stb = 6'h00;
  logic [7:0] mode = 8'h00;
  logic [1:0] ien = 2'h0;
  int        error_cnt = 0, compares = 0, sirq = 0, lirq = 0;
  wire logic sen, len, sto, lto, si, li, p4, o4, p5, o5, p6, o6;
  // Free-running clock and interrupt pulse counters.
  always #2 mclk = ~mclk;
  always @(posedge mclk)
  begin
    sirq <= sirq + (si === 1'b1);
    lirq <= lirq + (li === 1'b1);
  end
  pps_ping_pong_timer_sequencer u_pps_ping_pong_timer_sequencer (.mclk(mclk),
    .sys_rst(sys_rst), .short_enable_set(stb[0]), .short_enable_clr(stb[1]),
    .short_single_pass(sp), .short_int_enable(ien[0]), .short_pin_enable(pen),
    .short_timeout_clr(stb[2]), .long_enable_set(stb[3]), .long_enable_clr(stb[4]),
    .long_single_pass(sp), .long_int_enable(ien[1]), .long_pin_enable(pen),
    .long_timeout_clr(stb[5]), .shared_timer_mode_control(mode),
    .short_reload_high(8'h03), .short_reload_low(8'h05), .long_reload_high_byte(8'h00),
    .long_reload_low_byte(8'h04), .short_enabled_q(sen), .long_enabled_q(len),
    .short_timeout_q(sto), .long_timeout_q(lto), .short_irq_q(si), .long_irq_q(li),
    .port3_bit4_pin(p4), .port3_bit4_oe(o4), .port3_bit5_pin(p5), .port3_bit5_oe(o5),
    .port3_bit6_pin(p6), .port3_bit6_oe(o6));
  // Compare and count.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (error_cnt == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // One-cycle strobe on the selected control lines.
  task automatic pulse(input logic [5:0] m);
    @(posedge mclk) stb <= m;
    @(posedge mclk) stb <= 6'h00;
    #1;
  endtask
  // Counts the remaining cycles that a running timer stays enabled.
  task automatic run_len(input logic lng, input int exp);
    int n;
    n = 0;
    while ((lng ? len : sen) === 1'b1 && n < 300)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(n[15:0], exp[15:0]);
  endtask
  // Main sequence: ping-pong, stop, restart, then the combining pin.
  initial
  begin
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    pen <= 1'b1;
    ien <= 2'b10;
    mode <= 8'h06;
    pulse(6'h08);
    run_len(1'b1, 4);
    chk(p5, 1'b0);
    run_len(1'b0, 3);
    chk({p4, p5}, 2'b11);
    @(posedge mclk) mode <= 8'h02;
    #1;
    run_len(1'b1, 3);
    repeat (3) @(posedge mclk);
    #1;
    chk({p4, sen, sto, lto}, 4'h3);
    chk({o4, o5}, 2'b11);
    chk({sirq[7:0], lirq[7:0]}, 16'h0002);
    pulse(6'h24);
    chk({sto, lto}, 2'b00);
    @(posedge mclk) ien <= 2'b01;
    mode <= 8'h00;
    pulse(6'h01);
    pulse(6'h02);
    pulse(6'h01);
    run_len(1'b0, 5);
    repeat (2) @(posedge mclk);
    #1;
    chk({len, sirq[7:0]}, 9'h001);
    // Ping-pong code without single-pass must not hand over; pins released.
    @(posedge mclk) sp <= 1'b0;
    mode <= 8'h04;
    pen <= 1'b0;
    pulse(6'h01);
    repeat (8) @(posedge mclk);
    #1;
    chk({sen, len}, 2'b10);
    chk({o4, o5}, 2'b00);
    pulse(6'h02);
    // Forced long output codes, each against the opposite idle level.
    @(posedge mclk) sp <= 1'b1;
    mode <= 8'h08;
    repeat (2) @(posedge mclk);
    #1;
    chk(p5, 1'b0);
    @(posedge mclk) mode <= 8'h0D;
    repeat (2) @(posedge mclk);
    #1;
    chk(p5, 1'b1);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge mclk) mode <= {2'b01, i[1:0], 2'b00, i[3:2]};
      repeat (3) @(posedge mclk);
      #1;
      chk({o6, p6}, {1'b1, i[1] ^ ((i[0] ^ i[1]) ? ~(i[3] & i[2]) : ~(i[3] | i[2]))});
    end
    report_and_stop();
  end
  // Guard against a hang.
  initial
  begin
    repeat (5000) @(posedge mclk);
    error_cnt++;
    report_and_stop();
  end
endmodule
`default_nettype wire
